// ===== hw/dma_cfg.svh
// Purpose: constants of the data memory access unit
// Assumes: byte data space of 64K, 100 MHz system clock
// Notes:   io offsets are relative to the std io base, data address minus 0x20
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define DMA_REGFILE_SIZE   32
`define DMA_STDIO_SIZE     64
`define DMA_EXTIO_SIZE     416
`define DMA_ISRAM_SIZE     8192
`define DMA_ADDR_STDIO     16'h0020
`define DMA_ADDR_EXTIO     16'h0060
`define DMA_ADDR_ISRAM     16'h0200
`define DMA_ADDR_XSRAM     16'h2200
`define DMA_IO_CTRL        6'h3f
`define DMA_IO_EEDATA      6'h3e
`define DMA_IO_EEADRL      6'h3d
`define DMA_IO_EEADRH      6'h3c
`define DMA_IO_XCTRL       6'h3b
`define DMA_CTRL_RD_BIT    0
`define DMA_CTRL_WE_BIT    1
`define DMA_CTRL_MWE_BIT   2
`define DMA_XCTRL_SRE_BIT  7
`define DMA_XCTRL_WS_LSB   0
`define DMA_DISP_MAX       63
`define DMA_ISRAM_CYCLES   2
`define DMA_EE_RD_STALL    4
`define DMA_EE_WR_STALL    2
`define DMA_MWE_HOLD       4
`define DMA_EE_WR_RC       26368
`define DMA_STACK_PC_BYTES 3
`endif

// ===== hw/dma_pkg.sv
// Purpose: types of the data memory access unit
// Assumes: nothing
// Notes:   constants live in dma_cfg.svh
`default_nettype none
package dma_pkg;
  typedef enum logic [4:0] {
    DMA_RGN_REG   = 5'h01,
    DMA_RGN_STDIO = 5'h02,
    DMA_RGN_EXTIO = 5'h04,
    DMA_RGN_ISRAM = 5'h08,
    DMA_RGN_XSRAM = 5'h10
  } dma_region_t;
  typedef enum logic [2:0] {
    DMA_MODE_DIRECT = 3'h0,
    DMA_MODE_DISP   = 3'h1,
    DMA_MODE_IND    = 3'h2,
    DMA_MODE_PREDEC = 3'h3,
    DMA_MODE_POSTINC= 3'h4
  } dma_mode_t;
  typedef enum logic [3:0] {
    DMA_ST_IDLE = 4'h1,
    DMA_ST_INT  = 4'h2,
    DMA_ST_EXT  = 4'h4,
    DMA_ST_EE   = 4'h8
  } dma_state_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        io_op;
    logic        stack;
    logic        pc_op;
    dma_mode_t   mode;
    logic [15:0] ptr;
    logic [5:0]  disp;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dma_req_t;
  typedef struct packed {
    dma_state_t  st;
    logic        busy;
    logic [3:0]  cnt;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        stall;
    logic [15:0] ptr;
    logic        ptr_we;
    logic [4:0]  rgn;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic [7:0]  ad_o;
    logic        ad_oe;
    logic [7:0]  ahi;
    logic        ram_re;
    logic        ram_we;
    logic [7:0]  xctrl;
    logic [7:0]  ee_data;
    logic [11:0] ee_addr;
    logic        ee_we;
    logic        ee_mwe;
    logic [2:0]  mwe_cnt;
    logic        ee_rd;
    logic        ee_wr;
    logic        ee_pend;
  } dma_state_s_t;
endpackage
`default_nettype wire

// ===== hw/dma_unit.sv
// Purpose: data-space decode, access timing and eeprom port
// Assumes: one request accepted when idle; memories answer in the
//          same cycle as the strobe; rc ticks are single clk pulses
// Notes:   ext pins reflect one-byte xsram cycles
//
// Operation
// RQ1: addresses 0..31 select the working register file.
// RQ2: then 64 std io, 416 ext io, 8192 internal sram, ascending.
// RQ3: ext io reachable only by data-space load/store, not io opcodes.
// RQ4: external sram spans from internal top to 64K.
// RQ5: addresses beyond internal memory go to external sram.
// RQ6: ext strobes stay inactive throughout internal accesses.
// RQ7: external sram works only with the enable bit set.
// RQ8: external byte costs one cycle more than internal.
// RQ9: external stack adds three cycles per pc transfer.
// RQ10: wait states one to three add two to four cycles per byte.
// RQ11: with waits, pc transfers add five, seven or nine cycles.
// RQ12: displacement mode adds 0..63 to Y or Z base.
// RQ13: pointer pre-decrements or post-increments around the access.
// RQ14: internal sram access takes two cycles.
// RQ15: separate 4K eeprom, byte read and write.
// RQ16: eeprom read stalls four cycles, write start two.
// RQ17: write lasts 26368 rc oscillator cycles.
// RQ18: write enable stays set while the write is busy.
// RQ19: write starts only if master enable was set first.
// RQ20: software waits for prior write before new address/data.
// RQ21: software waits for flash store-program before eeprom write.
// RQ22: a reset does not abort a running eeprom write.
// RQ23: latch enable falls with address valid, low during data.
// RQ24: master enable clears itself a few cycles after set.
// RQ25: read loads data reg; reads during busy write ignored.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`include "dma_cfg.svh"
`default_nettype none
module dma_unit #(
  parameter int EE_WR_RC = `DMA_EE_WR_RC
) (
  input  wire logic              i_sys_clk,  // cpu clock
  input  wire logic              i_reset_n,  // async reset
  input  wire logic              i_por_n,    // power-on only
  input  wire dma_pkg::dma_req_t i_req,      // cpu access
  input  wire logic [7:0]        i_mem_rdata, // memory read data
  input  wire logic [7:0]        i_ad_i,     // muxed bus in
  input  wire logic              i_rc_tick,  // rc oscillator tick
  input  wire logic [7:0]        i_ee_rdata, // eeprom array data
  output logic                   o_busy,     // access in progress
  output logic                   o_stall,    // cpu halt
  output logic [7:0]             o_rdata,    // load result
  output logic                   o_rvalid,   // load result valid
  output logic [15:0]            o_ptr,      // updated pointer
  output logic                   o_ptr_we,   // pointer update
  output logic [4:0]             o_region,   // one-hot region
  output logic [15:0]            o_mem_addr, // memory address
  output logic [7:0]             o_mem_wdata, // memory write data
  output logic                   o_mem_re,   // internal read
  output logic                   o_mem_we,   // internal write
  output logic                   o_ale,      // address latch
  output logic                   o_ext_read_strobe_pin_n,  // rd
  output logic                   o_ext_write_strobe_pin_n, // wr
  output logic [7:0]             o_ad_o,     // muxed bus out
  output logic                   o_ad_oe,    // muxed bus drive
  output logic [7:0]             o_addr_hi,  // high address
  output logic [11:0]            o_ee_addr,  // eeprom address
  output logic [7:0]             o_ee_wdata, // eeprom data
  output logic                   o_ee_rd,    // eeprom read
  output logic                   o_ee_wr     // eeprom write busy
);
  if (EE_WR_RC < 1 || EE_WR_RC > 65535) begin : g_rc_check
    $error("EE_WR_RC out of range");
  end

  // ******************************
  // region decode
  // ******************************
  function automatic dma_pkg::dma_region_t region_of(
    input logic [15:0] a
  );
    if (a < `DMA_ADDR_STDIO) begin
      region_of = dma_pkg::DMA_RGN_REG; // RQ1
    end else if (a < `DMA_ADDR_EXTIO) begin
      region_of = dma_pkg::DMA_RGN_STDIO; // RQ2
    end else if (a < `DMA_ADDR_ISRAM) begin
      region_of = dma_pkg::DMA_RGN_EXTIO; // RQ2
    end else if (a < `DMA_ADDR_XSRAM) begin
      region_of = dma_pkg::DMA_RGN_ISRAM; // RQ2
    end else begin
      region_of = dma_pkg::DMA_RGN_XSRAM; // RQ4
    end
  endfunction

  // extra cycles beyond internal for one byte; ws 0..3 -> 1..4
  function automatic logic [3:0] ext_extra(input logic [1:0] ws);
    ext_extra = (ws == 2'h0) ? 4'h1 : 4'({2'h0, ws} + 4'h1); // RQ8 RQ10
  endfunction

  dma_pkg::dma_state_s_t s_q;
  dma_pkg::dma_state_s_t s_d;
  logic [15:0]           rc_cnt_q;
  logic [15:0]           rc_cnt_d;
  logic                  ee_wr_q;

  logic [15:0] eff_addr;
  logic [15:0] new_ptr;
  logic        do_ptr;
  logic [5:0]  io_addr;
  logic        io_hit;
  logic        external_sram_enable;
  logic [3:0]  xcyc;

  // ******************************
  // address formation
  // ******************************
  always_comb begin
    eff_addr = i_req.addr;
    new_ptr  = i_req.ptr;
    do_ptr   = 1'b0;
    case (i_req.mode)
      dma_pkg::DMA_MODE_DIRECT: eff_addr = i_req.addr;
      dma_pkg::DMA_MODE_DISP: begin
        eff_addr = i_req.ptr + {10'h000, i_req.disp}; // RQ12
      end
      dma_pkg::DMA_MODE_IND: eff_addr = i_req.ptr;
      dma_pkg::DMA_MODE_PREDEC: begin
        eff_addr = i_req.ptr - 16'h0001; // RQ13
        new_ptr  = eff_addr;
        do_ptr   = 1'b1;
      end
      dma_pkg::DMA_MODE_POSTINC: begin
        eff_addr = i_req.ptr; // RQ13
        new_ptr  = i_req.ptr + 16'h0001;
        do_ptr   = 1'b1;
      end
      default: eff_addr = i_req.addr;
    endcase
    // short io opcodes only cover the 64 std io; RQ3
    if (i_req.io_op) begin
      eff_addr = 16'(i_req.addr[5:0]) + `DMA_ADDR_STDIO;
    end
  end

  assign io_addr = 6'(eff_addr - `DMA_ADDR_STDIO);
  assign io_hit  = region_of(eff_addr) == dma_pkg::DMA_RGN_STDIO;
  assign external_sram_enable     = s_q.xctrl[`DMA_XCTRL_SRE_BIT];
  // pc transfers move three bytes; waits give 3,5,7,9
  assign xcyc = i_req.pc_op ?
      4'(`DMA_STACK_PC_BYTES + 2 * (ext_extra(s_q.xctrl[1:0]) - 4'h1))
      : ext_extra(s_q.xctrl[1:0]); // RQ9 RQ11

  // ******************************
  // next state
  // ******************************
  always_comb begin
    s_d        = s_q;
    rc_cnt_d   = rc_cnt_q;
    s_d.rvalid = 1'b0;
    s_d.ptr_we = 1'b0;
    s_d.ram_re = 1'b0;
    s_d.ram_we = 1'b0;
    s_d.ee_rd  = 1'b0;
    s_d.wr_n   = 1'b1;
    s_d.rd_n   = 1'b1;
    // master enable times out; RQ24
    if (s_q.ee_mwe) begin
      if (s_q.mwe_cnt == 3'h0) begin
        s_d.ee_mwe = 1'b0;
      end else begin
        s_d.mwe_cnt = s_q.mwe_cnt - 3'h1;
      end
    end
    // self-timed write; RQ17 RQ18
    if (ee_wr_q && i_rc_tick) begin
      if (rc_cnt_q == 16'(EE_WR_RC - 1)) begin
        s_d.ee_wr = 1'b0;
        s_d.ee_we = 1'b0;
        rc_cnt_d  = 16'h0000;
      end else begin
        rc_cnt_d = rc_cnt_q + 16'h0001;
      end
    end
    case (s_q.st)
      dma_pkg::DMA_ST_IDLE: begin
        s_d.stall = 1'b0;
        s_d.busy  = 1'b0;
        if (i_req.valid) begin
          s_d.addr  = eff_addr;
          s_d.wdata = i_req.wdata;
          s_d.wr    = i_req.write;
          s_d.rgn   = region_of(eff_addr);
          s_d.ptr   = new_ptr;
          s_d.ptr_we = do_ptr; // RQ13
          s_d.busy  = 1'b1;
          if (io_hit && i_req.write && io_addr == `DMA_IO_CTRL) begin
            // arming then enable; RQ19
            if (i_req.wdata[`DMA_CTRL_MWE_BIT]) begin
              s_d.ee_mwe  = 1'b1;
              s_d.mwe_cnt = 3'(`DMA_MWE_HOLD - 1);
            end
            if (i_req.wdata[`DMA_CTRL_WE_BIT] && s_q.ee_mwe
                && !ee_wr_q) begin
              s_d.ee_we  = 1'b1; // RQ18
              s_d.ee_wr  = 1'b1;
              s_d.ee_mwe = 1'b0;
              rc_cnt_d   = 16'h0000;
              s_d.st     = dma_pkg::DMA_ST_EE;
              s_d.stall  = 1'b1;
              s_d.cnt    = 4'(`DMA_EE_WR_STALL - 1); // RQ16
            end else if (i_req.wdata[`DMA_CTRL_RD_BIT]
                         && !ee_wr_q) begin
              s_d.ee_rd = 1'b1; // RQ25
              s_d.st    = dma_pkg::DMA_ST_EE;
              s_d.stall = 1'b1;
              s_d.cnt   = 4'(`DMA_EE_RD_STALL - 1); // RQ16
            end else begin
              s_d.st  = dma_pkg::DMA_ST_INT;
              s_d.cnt = 4'h0;
            end
          end else if (region_of(eff_addr) == dma_pkg::DMA_RGN_XSRAM
                       && external_sram_enable) begin
            // external cycle; RQ5 RQ7
            s_d.st    = dma_pkg::DMA_ST_EXT;
            s_d.cnt   = xcyc;
            s_d.stall = 1'b1;
            s_d.ale   = 1'b1;
            s_d.ad_o  = eff_addr[7:0];
            s_d.ad_oe = 1'b1;
            s_d.ahi   = eff_addr[15:8];
          end else begin
            s_d.st = dma_pkg::DMA_ST_INT; // RQ14
            s_d.cnt = 4'(`DMA_ISRAM_CYCLES - 2);
            s_d.ram_re = !i_req.write;
            s_d.ram_we = i_req.write && !io_hit;
            if (io_hit && i_req.write) begin
              case (io_addr)
                `DMA_IO_EEDATA: s_d.ee_data = i_req.wdata;
                `DMA_IO_EEADRL: s_d.ee_addr[7:0] = i_req.wdata;
                `DMA_IO_EEADRH: s_d.ee_addr[11:8] = i_req.wdata[3:0]; // RQ15
                `DMA_IO_XCTRL: s_d.xctrl = i_req.wdata;
                default: s_d.ram_we = 1'b1;
              endcase
            end
          end
        end
      end
      dma_pkg::DMA_ST_INT: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st     = dma_pkg::DMA_ST_IDLE;
          s_d.busy   = 1'b0;
          s_d.rvalid = !s_q.wr;
          s_d.rdata  = i_mem_rdata;
          if (s_q.rgn == 5'(dma_pkg::DMA_RGN_STDIO)) begin
            case (6'(s_q.addr - `DMA_ADDR_STDIO))
              `DMA_IO_CTRL: s_d.rdata = {5'h00, s_q.ee_mwe, ee_wr_q,
                                         1'b0};
              `DMA_IO_EEDATA: s_d.rdata = s_q.ee_data;
              `DMA_IO_EEADRL: s_d.rdata = s_q.ee_addr[7:0];
              `DMA_IO_EEADRH: s_d.rdata = {4'h0, s_q.ee_addr[11:8]};
              `DMA_IO_XCTRL: s_d.rdata = s_q.xctrl;
              default: s_d.rdata = i_mem_rdata;
            endcase
          end
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      dma_pkg::DMA_ST_EXT: begin
        // ale low with data phase; RQ23
        s_d.ale   = 1'b0;
        s_d.ad_o  = s_q.wdata;
        s_d.ad_oe = s_q.wr;
        s_d.wr_n  = !s_q.wr;
        s_d.rd_n  = s_q.wr;
        if (s_q.cnt == 4'h0) begin
          s_d.st     = dma_pkg::DMA_ST_IDLE;
          s_d.busy   = 1'b0;
          s_d.stall  = 1'b0;
          s_d.wr_n   = 1'b1;
          s_d.rd_n   = 1'b1;
          s_d.ad_oe  = 1'b0;
          s_d.rvalid = !s_q.wr;
          s_d.rdata  = i_ad_i;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      dma_pkg::DMA_ST_EE: begin
        if (s_q.cnt == 4'h0) begin
          s_d.st    = dma_pkg::DMA_ST_IDLE;
          s_d.busy  = 1'b0;
          s_d.stall = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
          if (s_q.cnt == 4'(`DMA_EE_RD_STALL - 2)) begin
            s_d.ee_data = i_ee_rdata; // RQ25
          end
        end
      end
      default: s_d.st = dma_pkg::DMA_ST_IDLE;
    endcase
    if (s_q.st != dma_pkg::DMA_ST_EXT && s_d.st != dma_pkg::DMA_ST_EXT) begin
      s_d.wr_n = 1'b1; // RQ6
      s_d.rd_n = 1'b1;
    end
  end

  // ******************************
  // registers
  // ******************************
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q     <= '0;
      s_q.st  <= dma_pkg::DMA_ST_IDLE;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // write engine survives cpu reset; RQ22
  always_ff @(posedge i_sys_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      ee_wr_q  <= 1'b0;
      rc_cnt_q <= 16'h0000;
    end else begin
      ee_wr_q  <= s_d.ee_wr | (ee_wr_q & ~(i_rc_tick
                  & rc_cnt_q == 16'(EE_WR_RC - 1)));
      rc_cnt_q <= rc_cnt_d;
    end
  end

  assign o_busy      = s_q.busy;
  assign o_stall     = s_q.stall;
  assign o_rdata     = s_q.rdata;
  assign o_rvalid    = s_q.rvalid;
  assign o_ptr       = s_q.ptr;
  assign o_ptr_we    = s_q.ptr_we;
  assign o_region    = s_q.rgn;
  assign o_mem_addr  = s_q.addr;
  assign o_mem_wdata = s_q.wdata;
  assign o_mem_re    = s_q.ram_re;
  assign o_mem_we    = s_q.ram_we;
  assign o_ale       = s_q.ale;
  assign o_ext_read_strobe_pin_n  = s_q.rd_n;
  assign o_ext_write_strobe_pin_n = s_q.wr_n;
  assign o_ad_o      = s_q.ad_o;
  assign o_ad_oe     = s_q.ad_oe;
  assign o_addr_hi   = s_q.ahi;
  assign o_ee_addr   = s_q.ee_addr;
  assign o_ee_wdata  = s_q.ee_data;
  assign o_ee_rd     = s_q.ee_rd;
  assign o_ee_wr     = ee_wr_q;

  // ******************************
  // checks
  // ******************************
  a_int_no_strobe: assert property (@(posedge i_sys_clk) // RQ6
    disable iff (!i_reset_n) s_q.st == dma_pkg::DMA_ST_INT
    |-> s_q.rd_n && s_q.wr_n) else $error("strobe in internal access");
  a_ext_needs_sre: assert property (@(posedge i_sys_clk) // RQ7
    disable iff (!i_reset_n) $rose(s_q.st == dma_pkg::DMA_ST_EXT)
    |-> $past(external_sram_enable)) else $error("external access while disabled");
  a_isram_two_cyc: assert property (@(posedge i_sys_clk) // RQ14
    disable iff (!i_reset_n)
    (s_q.st == dma_pkg::DMA_ST_IDLE && s_d.st == dma_pkg::DMA_ST_INT
     && !io_hit) |=> ##1 (s_q.st == dma_pkg::DMA_ST_IDLE))
    else $error("internal access length");
  a_ee_read_stall: assert property (@(posedge i_sys_clk) // RQ16
    disable iff (!i_reset_n) $rose(s_q.ee_rd) |-> s_q.stall[*4]
    ##1 !s_q.stall) else $error("eeprom read stall length");
  a_we_needs_arm: assert property (@(posedge i_sys_clk) // RQ19
    disable iff (!i_reset_n) $rose(s_q.ee_we) |-> $past(s_q.ee_mwe))
    else $error("write without arming");
  a_mwe_timeout: assert property (@(posedge i_sys_clk) // RQ24
    disable iff (!i_reset_n) $rose(s_q.ee_mwe) |-> ##[1:5] !s_q.ee_mwe)
    else $error("master enable stuck");
  a_ale_low_data: assert property (@(posedge i_sys_clk) // RQ23
    disable iff (!i_reset_n) !s_q.rd_n || !s_q.wr_n |-> !s_q.ale)
    else $error("latch enable high during data");
  a_region_map: assert property (@(posedge i_sys_clk) // RQ1
    disable iff (!i_reset_n) s_q.busy && s_q.addr < 16'h0020
    |-> s_q.rgn == 5'h01) else $error("register file decode");
endmodule
`default_nettype wire

// ===== testbench/dma_mem_model.sv
// Purpose: far side of the access unit: memories, ext sram, eeprom
// Assumes: memories answer while the strobe stands
// Notes:   idle bus lines show a pattern that changes every cycle
`default_nettype none
module dma_mem_model (
  input  wire logic        i_sys_clk,   // cpu clock
  input  wire logic [15:0] i_mem_addr,  // internal address
  input  wire logic [7:0]  i_mem_wdata, // internal write data
  input  wire logic        i_mem_re,    // internal read
  input  wire logic        i_mem_we,    // internal write
  input  wire logic        i_ale,       // address latch enable
  input  wire logic        i_rd_n,      // ext read strobe
  input  wire logic        i_wr_n,      // ext write strobe
  input  wire logic [7:0]  i_ad,        // muxed bus level
  input  wire logic [7:0]  i_addr_hi,   // high address
  input  wire logic [11:0] i_ee_addr,   // eeprom address
  input  wire logic [7:0]  i_ee_wdata,  // eeprom data
  input  wire logic        i_ee_rd,     // eeprom read
  input  wire logic        i_ee_wr,     // eeprom write busy
  output logic [7:0]       o_mem_rdata, // internal read data
  output logic [7:0]       o_ad_drv,    // ext sram drive
  output logic             o_rc_tick,   // rc oscillator tick
  output logic [7:0]       o_ee_rdata   // eeprom array data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem  [0:65535];
  logic [7:0]  external_memory_port [0:65535];
  logic [7:0]  ee   [0:4095];
  logic [15:0] xa;
  logic [7:0]  idle_q;
  logic [1:0]  div_q;
  logic        eew_q;
  // ****************************************
  // contents and timing
  // ****************************************
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
      external_memory_port[i] = 8'(i) ^ 8'ha5;
    end
    for (int i = 0; i < 4096; i++) begin
      ee[i] = 8'hff;
    end
    idle_q = 8'h00;
    div_q = 2'h0;
    eew_q = 1'b0;
    o_rc_tick = 1'b0;
    o_ee_rdata = 8'h00;
  end
  // address byte taken on the edge at which ale is seen high
  assign o_ad_drv    = i_rd_n ? idle_q : external_memory_port[xa];
  assign o_mem_rdata = i_mem_re ? mem[i_mem_addr] : idle_q;
  always @(posedge i_sys_clk) begin
    idle_q <= idle_q + 8'h3b;
    div_q <= div_q + 2'h1;
    o_rc_tick <= (div_q == 2'h3);
    eew_q <= i_ee_wr;
    if (i_ale) xa <= {i_addr_hi, i_ad};
    o_ee_rdata <= i_ee_rd ? ee[i_ee_addr] : ~o_ee_rdata;
    if (i_mem_we) mem[i_mem_addr] <= i_mem_wdata;
    if (!i_wr_n) external_memory_port[xa] <= i_ad;
    if (i_ee_wr && !eew_q) ee[i_ee_addr] <= i_ee_wdata;
  end
endmodule
`default_nettype wire

// ===== testbench/data_memory_access_unit_bench.sv
// Purpose: self-checking bench of the data memory access unit
// Assumes: eeprom write shortened to 8 rc ticks
// Notes:   requests are one cycle, next one after busy falls
`include "dma_cfg.svh"
`default_nettype none
module data_memory_access_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC_CNT = 8;
  logic              i_sys_clk, i_reset_n, i_por_n;
  dma_pkg::dma_req_t i_req, r;
  logic [7:0]        mem_rdata, ad_i, ad_drv, ee_rdata, ad_o, rdata, d;
  logic [7:0]        mem_wdata, ee_wdata, addr_hi, rd_seen;
  logic              rc_tick, busy, stall, rvalid, ptr_we, mem_re, mem_we;
  logic              ale, rd_n, wr_n, ad_oe, ee_rd, ee_wr;
  logic [15:0]       ptr, mem_addr, addr_seen, ptr_seen;
  logic [4:0]        region, rgn_seen;
  logic [11:0]       ee_addr;
  int                err_count, checks, cyc, stall_cnt, tick_cnt, strb_cnt;
  int                n, ni, ne;
  logic [15:0] ra [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
    16'h0060, 16'h01ff, 16'h0200, 16'h21ff, 16'h2200, 16'hffff};
  logic [4:0]  re [10] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h04,
    5'h08, 5'h08, 5'h10, 5'h10};
  dma_pkg::dma_mode_t pm [3] = '{dma_pkg::DMA_MODE_POSTINC,
    dma_pkg::DMA_MODE_PREDEC, dma_pkg::DMA_MODE_DISP};
  logic [15:0] pa [3] = '{16'h0300, 16'h02ff, 16'h033f};
  logic [15:0] pp [3] = '{16'h0301, 16'h02ff, 16'h0300};
  assign ad_i = ad_oe ? ad_o : ad_drv;
  dma_unit #(.EE_WR_RC(RC_CNT)) u_dma_unit (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
    .i_req(i_req), .i_mem_rdata(mem_rdata), .i_ad_i(ad_i),
    .i_rc_tick(rc_tick), .i_ee_rdata(ee_rdata), .o_busy(busy),
    .o_stall(stall), .o_rdata(rdata), .o_rvalid(rvalid), .o_ptr(ptr),
    .o_ptr_we(ptr_we), .o_region(region), .o_mem_addr(mem_addr),
    .o_mem_wdata(mem_wdata), .o_mem_re(mem_re), .o_mem_we(mem_we),
    .o_ale(ale), .o_ext_read_strobe_pin_n(rd_n),
    .o_ext_write_strobe_pin_n(wr_n), .o_ad_o(ad_o), .o_ad_oe(ad_oe),
    .o_addr_hi(addr_hi), .o_ee_addr(ee_addr), .o_ee_wdata(ee_wdata),
    .o_ee_rd(ee_rd), .o_ee_wr(ee_wr));
  dma_mem_model u_dma_mem_model (
    .i_sys_clk(i_sys_clk), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
    .i_mem_re(mem_re), .i_mem_we(mem_we), .i_ale(ale), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_ad(ad_i), .i_addr_hi(addr_hi), .i_ee_addr(ee_addr),
    .i_ee_wdata(ee_wdata), .i_ee_rd(ee_rd), .i_ee_wr(ee_wr),
    .o_mem_rdata(mem_rdata), .o_ad_drv(ad_drv), .o_rc_tick(rc_tick),
    .o_ee_rdata(ee_rdata));
  // ****************************************
  // clock, monitors, tasks
  // ****************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (stall === 1'b1) stall_cnt <= stall_cnt + 1;
    if (rc_tick === 1'b1 && ee_wr === 1'b1) tick_cnt <= tick_cnt + 1;
    if (rd_n === 1'b0 || wr_n === 1'b0) strb_cnt <= strb_cnt + 1;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic dma_pkg::dma_req_t mk(logic w, logic [15:0] a,
                                           logic [7:0] wd);
    mk = '0;
    mk.valid = 1'b1;
    mk.write = w;
    mk.mode = dma_pkg::DMA_MODE_DIRECT;
    mk.addr = a;
    mk.wdata = wd;
  endfunction
  task automatic idle(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  // one request, cycles counted from the taking edge
  task automatic go(input dma_pkg::dma_req_t q, output int c);
    @(posedge i_sys_clk);
    i_req <= q;
    c = 0;
    do begin
      @(posedge i_sys_clk);
      if (c == 0) i_req.valid <= 1'b0;
      #1;
      c++;
      if (c == 1) rgn_seen = region;
      if (mem_re === 1'b1) addr_seen = mem_addr;
      if (ptr_we === 1'b1) ptr_seen = ptr;
      if (rvalid === 1'b1) rd_seen = rdata;
    end while ((busy !== 1'b0 || stall !== 1'b0) && c < 100);
  endtask
  task automatic wio(input logic [5:0] off, input logic [7:0] wd);
    int c;
    go(mk(1'b1, 16'h0020 + {10'h000, off}, wd), c);
  endtask
  task automatic rio(input logic [5:0] off, output logic [7:0] rd);
    int c;
    go(mk(1'b0, 16'h0020 + {10'h000, off}, 8'h00), c);
    rd = rd_seen;
  endtask
  task automatic ee_write(input logic [11:0] a, input logic [7:0] wd);
    logic [7:0] s;
    int k;
    k = 0;
    do begin
      rio(`DMA_IO_CTRL, s);
      k++;
    end while (s[1] !== 1'b0 && k < 100);
    wio(`DMA_IO_EEADRH, {4'h0, a[11:8]});
    wio(`DMA_IO_EEADRL, a[7:0]);
    wio(`DMA_IO_EEDATA, wd);
    wio(`DMA_IO_CTRL, 8'h04);
    stall_cnt = 0;
    tick_cnt = 0;
    wio(`DMA_IO_CTRL, 8'h06);
  endtask
  task automatic ee_done();
    int k;
    k = 0;
    while (ee_wr !== 1'b0 && k < 500) begin
      idle(1);
      k++;
    end
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {i_reset_n, i_por_n, i_req} = '0;
    {err_count, checks, cyc, stall_cnt, tick_cnt, strb_cnt} = '0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    i_por_n <= 1'b1;
    strb_cnt = 0;
    go(mk(1'b0, 16'h0234, 8'h00), n);
    chk("isram cycles", 16'(n), 16'd2);
    chk("isram data", 16'(rd_seen), 16'h006e);
    chk("int strobes", 16'(strb_cnt), 16'd0);
    go(mk(1'b0, 16'h2234, 8'h00), n);
    chk("ext off strobes", 16'(strb_cnt), 16'd0);
    for (int ws = 0; ws < 4; ws++) begin
      wio(`DMA_IO_XCTRL, 8'h80 | 8'(ws));
      go(mk(1'b0, 16'h0234, 8'h00), ni);
      strb_cnt = 0;
      go(mk(1'b0, 16'h2234, 8'h00), ne);
      chk("ext extra", 16'(ne - ni), 16'(ws == 0 ? 1 : ws + 1));
      chk("ext data", 16'(rd_seen), 16'h0091);
      chk("ext strobe", 16'(strb_cnt > 0), 16'd1);
      r = mk(1'b1, 16'h0300, 8'h11);
      r.stack = 1'b1;
      r.pc_op = 1'b1;
      go(r, ni);
      r.addr = 16'h2300;
      go(r, ne);
      chk("pc extra", 16'(ne - ni), 16'(ws == 0 ? 3 : 2 * ws + 3));
    end
    go(mk(1'b1, 16'h2345, 8'h3c), n);
    chk("ext store", 16'(u_dma_mem_model.external_memory_port[16'h2345]), 16'h003c);
    r = mk(1'b0, 16'h003b, 8'h00);
    r.io_op = 1'b1;
    go(r, n);
    chk("io opcode", 16'(rd_seen), 16'h0083);
    for (int i = 0; i < 10; i++) begin
      go(mk(1'b0, ra[i], 8'h00), n);
      chk("region", 16'(rgn_seen), 16'(re[i]));
    end
    for (int i = 0; i < 3; i++) begin
      r = mk(1'b0, 16'h0000, 8'h00);
      r.mode = pm[i];
      r.ptr = 16'h0300;
      r.disp = 6'h3f;
      ptr_seen = 16'h0300;
      addr_seen = 16'h0000;
      go(r, n);
      chk("ptr addr", addr_seen, pa[i]);
      chk("ptr update", ptr_seen, pp[i]);
    end
    wio(`DMA_IO_CTRL, 8'h02);
    idle(4);
    chk("ee unarmed", 16'(ee_wr), 16'd0);
    wio(`DMA_IO_CTRL, 8'h04);
    idle(6);
    wio(`DMA_IO_CTRL, 8'h02);
    idle(2);
    chk("ee late arm", 16'(ee_wr), 16'd0);
    ee_write(12'hf21, 8'hc3);
    chk("ee write stall", 16'(stall_cnt), 16'd2);
    chk("ee busy", 16'(ee_wr), 16'd1);
    rio(`DMA_IO_CTRL, d);
    chk("ee busy bit", 16'(d[1]), 16'd1);
    go(mk(1'b1, 16'h005f, 8'h01), n);
    chk("ee read busy", 16'(n), 16'd2);
    ee_done();
    chk("ee ticks", 16'(tick_cnt), 16'(RC_CNT));
    chk("ee array", 16'(u_dma_mem_model.ee[12'hf21]), 16'h00c3);
    wio(`DMA_IO_EEDATA, 8'h00);
    stall_cnt = 0;
    wio(`DMA_IO_CTRL, 8'h01);
    idle(2);
    chk("ee read stall", 16'(stall_cnt), 16'd4);
    rio(`DMA_IO_EEDATA, d);
    chk("ee read data", 16'(d), 16'h00c3);
    ee_write(12'h010, 8'h5a);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1;
    chk("ee kept on reset", 16'(ee_wr), 16'd1);
    ee_done();
    chk("ee reset array", 16'(u_dma_mem_model.ee[12'h010]), 16'h005a);
    chk("ee reset done", 16'(ee_wr), 16'd0);
    end_of_test();
  end
endmodule
`default_nettype wire
